// ### hw/pgacr_pkg.sv
// package: register map, field layout and carrier types of the amplifier config bank
package pgacr_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses on the bus are four times these)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_RSV_A = 8'h0E;
	localparam logic [7:0] IDX_RSV_B = 8'h0F;
	localparam logic [7:0] IDX_SWGAIN = 8'h10;
	localparam logic [7:0] IDX_ALARM = 8'h11;
	localparam logic [7:0] IDX_CRCREV = 8'h12;
	localparam logic [7:0] IDX_IRQSTAT = 8'h13;
	localparam logic [7:0] IDX_IRQMASK = 8'h14;
	localparam int ADDR_W = 8;
	localparam int IDX_LSB = 2;
	// ----------------------------------------------------------------
	// reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] SWGAIN_RST = 8'h50;
	localparam logic [7:0] RSV_RST = 8'h00;
	localparam logic [2:0] SW_EXTERNAL = 3'h0;
	localparam logic [2:0] SW_INT_CM = 3'h5;
	localparam logic [3:0] GAIN_MIN = 4'h0;
	localparam logic [3:0] GAIN_MAX = 4'hB;
	localparam int SW_HI = 6;
	localparam int SW_LO = 4;
	localparam int GAIN_HI = 3;
	localparam int CRC_BIT = 4;
	localparam int IRQ_ALARM_BIT = 0;
	localparam int IRQ_CRC_BIT = 1;
	localparam int IRQ_W = 2;
	// revision value is arbitrary
	localparam logic [3:0] REV_DEFAULT = 4'h1;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic outNegLowAlarm;
		logic outNegHighAlarm;
		logic outPosLowAlarm;
		logic outPosHighAlarm;
		logic inNegLowAlarm;
		logic inNegHighAlarm;
		logic inPosLowAlarm;
		logic inPosHighAlarm;
	} pgacr_alarm_t;

	typedef struct packed {
		logic [2:0] inputSwitchSelect;
		logic [3:0] gainSelect;
	} pgacr_cfg_t;
endpackage

// ### hw/pgacr_sticky.sv
// sticky flag bank: set wins over clear
`timescale 1ns/1ps
module pgacr_sticky #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [W-1:0] setIn,
	input wire logic [W-1:0] clrIn,
	output logic [W-1:0] flags
);
	typedef struct packed {
		logic [W-1:0] flags;
	} pgacr_stk_t;
	pgacr_stk_t state_ff;
	pgacr_stk_t nxt_state;

	always_comb begin
		nxt_state = state_ff;
		nxt_state.flags = (state_ff.flags & ~clrIn) | setIn;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign flags = state_ff.flags;
endmodule // pgacr_sticky

// ### hw/pgacr_regs.sv
// amplifier input switch, gain, alarm and crc status register bank
// Contract
// [RULE1] mode bits 6:4 pick input: 000 external, 101 internal common mode (default)
// [RULE2] mode bits 3:0 pick gain 0.125 up to 128; 1100-1111 reserved
// [RULE3] mode register at 10h, resets to 50h
// [RULE4] alarm register holds eight read-only flags, 1 means alarm active
// [RULE5] alarm register at 11h clears on read; reset value undefined
// [RULE6] bit 4 of status two sets on crc error under second chip select
// [RULE7] crc flag stays set until host writes 0 to it
// [RULE8] status two bits 3:0 are a read-only revision nibble
// [RULE9] reserved register 0Fh reads 00h; host writes only 00h there
// [RULE10] host writes zero to reserved mode bit 7 and status bits 7:5
// [RULE11] status two at 12h; upper bits reset zero, low nibble revision
// [RULE12] writes to read-only fields leave contents unchanged
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module pgacr_regs
	import pgacr_pkg::*;
#(
	parameter logic [3:0] REV_ID = REV_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic [7:0] alarmEvent,
	input wire logic secondSelectCrcError,
	output pgacr_cfg_t ampConfig,
	output logic irq
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] swGain;
		pgacr_alarm_t alarm;
		logic crcError;
		logic [IRQ_W-1:0] irqMask;
		logic [31:0] rdData;
		logic [1:0] resp;
		logic ack;
	} pgacr_state_t;

	pgacr_state_t state_ff;
	pgacr_state_t nxt_state;

	logic [7:0] alarmSync1_ff;
	logic [7:0] alarmSync2_ff;
	logic crcSync1_ff;
	logic crcSync2_ff;

	logic [5:0] idx;
	logic req;
	logic take;
	logic wrLane0;
	logic [7:0] wb;
	logic [7:0] crcRevByte;
	logic [IRQ_W-1:0] irqSet;
	logic [IRQ_W-1:0] irqClr;
	logic [IRQ_W-1:0] irqStatus;
	logic alarmRead;

	// ----------------------------------------------------------------
	// event synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			alarmSync1_ff <= '0;
			alarmSync2_ff <= '0;
			crcSync1_ff <= 1'b0;
			crcSync2_ff <= 1'b0;
		end else begin
			alarmSync1_ff <= alarmEvent;
			alarmSync2_ff <= alarmSync1_ff;
			crcSync1_ff <= secondSelectCrcError;
			crcSync2_ff <= crcSync1_ff;
		end
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign idx = avs_address[ADDR_W-1:IDX_LSB];
	assign req = avs_read | avs_write;
	// one wait cycle per access, answered on the following edge
	assign take = req & ~state_ff.ack;
	assign wrLane0 = take & avs_write & avs_byteenable[0];
	assign wb = avs_writedata[7:0];
	assign crcRevByte = {3'h0, state_ff.crcError, REV_ID}; // [RULE8] [RULE11]
	assign alarmRead = take & avs_read & ({2'h0, idx} == IDX_ALARM);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.ack = take;
		nxt_state.resp = 2'h0;
		// alarms latch from the comparators, read clears, new alarm wins
		nxt_state.alarm = state_ff.alarm & ~{8{alarmRead}}; // [RULE5]
		nxt_state.alarm = nxt_state.alarm | alarmSync2_ff; // [RULE4]
		// crc flag: host zero clears, detection wins
		if (wrLane0 && ({2'h0, idx} == IDX_CRCREV) && !wb[CRC_BIT]) begin
			nxt_state.crcError = 1'b0; // [RULE7]
		end
		if (crcSync2_ff) begin
			nxt_state.crcError = 1'b1; // [RULE6]
		end
		if (wrLane0) begin
			case ({2'h0, idx})
				IDX_SWGAIN: begin
					nxt_state.swGain = wb; // [RULE1] [RULE2]
				end
				IDX_IRQMASK: begin
					nxt_state.irqMask = wb[IRQ_W-1:0];
				end
				default: begin
					// read-only and reserved locations ignore writes
					nxt_state.swGain = nxt_state.swGain; // [RULE12]
				end
			endcase
		end
		if (take && avs_read) begin
			case ({2'h0, idx})
				IDX_RSV_A: nxt_state.rdData = {24'h0, RSV_RST};
				IDX_RSV_B: nxt_state.rdData = {24'h0, RSV_RST}; // [RULE9]
				IDX_SWGAIN: nxt_state.rdData = {24'h0, state_ff.swGain};
				IDX_ALARM: nxt_state.rdData = {24'h0, state_ff.alarm};
				IDX_CRCREV: nxt_state.rdData = {24'h0, crcRevByte};
				IDX_IRQSTAT: nxt_state.rdData = {30'h0, irqStatus};
				IDX_IRQMASK: nxt_state.rdData = {30'h0, state_ff.irqMask};
				default: begin
					nxt_state.rdData = 32'h0;
					nxt_state.resp = 2'h2;
				end
			endcase
		end else if (take) begin
			case ({2'h0, idx})
				IDX_RSV_A, IDX_RSV_B, IDX_SWGAIN, IDX_ALARM,
				IDX_CRCREV, IDX_IRQSTAT, IDX_IRQMASK: nxt_state.resp = 2'h0;
				default: nxt_state.resp = 2'h2;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_ff.swGain <= SWGAIN_RST; // [RULE3]
			state_ff.alarm <= '0;
			state_ff.crcError <= 1'b0; // [RULE11]
			state_ff.irqMask <= '0;
			state_ff.rdData <= '0;
			state_ff.resp <= 2'h0;
			state_ff.ack <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status: alarm and crc events, write one to clear
	// ----------------------------------------------------------------
	always_comb begin
		irqSet = '0;
		irqSet[IRQ_ALARM_BIT] = |alarmSync2_ff;
		irqSet[IRQ_CRC_BIT] = crcSync2_ff;
		irqClr = '0;
		if (wrLane0 && ({2'h0, idx} == IDX_IRQSTAT)) begin
			irqClr = wb[IRQ_W-1:0];
		end
	end

	pgacr_sticky #(
		.W(IRQ_W)
	) uIrqStatus (
		.ref_clk(ref_clk),
		.srst(srst),
		.setIn(irqSet),
		.clrIn(irqClr),
		.flags(irqStatus)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_waitrequest = req & ~state_ff.ack;
	assign avs_readdata = state_ff.rdData;
	assign avs_response = state_ff.resp;
	assign ampConfig.inputSwitchSelect = state_ff.swGain[SW_HI:SW_LO]; // [RULE1]
	assign ampConfig.gainSelect = state_ff.swGain[GAIN_HI:0]; // [RULE2]
	assign irq = |(irqStatus & state_ff.irqMask);
endmodule // pgacr_regs

// ### tb/pgacr_event_src.sv
// event source standing in for the alarm comparators and crc checker
`timescale 1ns/1ps
module pgacr_event_src (
	input wire logic ref_clk,
	input wire logic fire,
	input wire logic [8:0] pattern,
	output logic [7:0] alarmEvent,
	output logic secondSelectCrcError
);
	logic [8:0] level_ff = 9'h000;
	logic [2:0] hold_ff = 3'h0;
	assign {secondSelectCrcError, alarmEvent} = level_ff;
	always_ff @(posedge ref_clk) begin
		if (fire) begin
			level_ff <= pattern;
			hold_ff <= 3'h4;
		end else if (hold_ff != 3'h0) begin
			hold_ff <= hold_ff - 3'h1;
		end else begin
			level_ff <= 9'h000;
		end
	end
endmodule // pgacr_event_src

// ### tb/pgacr_regs_sva.sv
// checker: bus timing and register behaviour at the bank's ports
`timescale 1ns/1ps
module pgacr_regs_chk
	import pgacr_pkg::*;
#(
	parameter logic [3:0] REV_ID = REV_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [1:0] avs_response,
	input wire logic [7:0] alarmEvent,
	input wire logic secondSelectCrcError,
	input wire pgacr_cfg_t ampConfig,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	logic rdAns;
	assign rdAns = avs_read && !avs_waitrequest;
	sequence s_take;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_cfgWr;
		s_take ##0 avs_write && avs_address == 8'h40 && avs_byteenable[0];
	endsequence
	property p_answer; s_take |=> !avs_waitrequest; endproperty
	property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
	property p_cfgReset; $past(srst) |-> ampConfig == 7'h50; endproperty
	property p_cfgWrite; s_cfgWr |=> ampConfig == $past(avs_writedata[6:0]); endproperty
	property p_cfgHold;
		$changed(ampConfig) |-> $past(avs_write && avs_waitrequest && avs_address == 8'h40);
	endproperty
	property p_rsvRead;
		rdAns && avs_address inside {8'h38, 8'h3C} |-> avs_readdata == 32'h0;
	endproperty
	property p_crcRev;
		rdAns && avs_address == 8'h48 |-> avs_readdata[31:5] == 27'h0 && avs_readdata[3:0] == REV_ID;
	endproperty
	property p_unmapped;
		rdAns && (avs_address[7:2] < 6'h0E || avs_address[7:2] > 6'h14)
			|-> avs_response == 2'h2 && avs_readdata == 32'h0;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after one wait cycle");
	a_idle: assert property (p_idle) else $error("waitrequest high while idle");
	a_cfgReset: assert property (p_cfgReset) else $error("mode not 50h after reset");
	a_cfgWrite: assert property (p_cfgWrite) else $error("mode write lost");
	a_cfgHold: assert property (p_cfgHold) else $error("mode changed unasked");
	a_rsvRead: assert property (p_rsvRead) else $error("reserved not zero");
	a_crcRev: assert property (p_crcRev) else $error("status two layout wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
endmodule // pgacr_regs_chk
bind pgacr_regs pgacr_regs_chk #(.REV_ID(REV_ID)) i_chk (.ref_clk(ref_clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.avs_response(avs_response), .alarmEvent(alarmEvent),
	.secondSelectCrcError(secondSelectCrcError), .ampConfig(ampConfig), .irq(irq));

// ### tb/pgacr_regs_bench.sv
// bench: bus scenarios for the amplifier config bank
`timescale 1ns/1ps
module pgacr_regs_bench;
	import pgacr_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, irq, secondSelectCrcError, fire = 1'b0;
	logic [1:0] avs_response, rsp;
	logic [7:0] alarmEvent;
	logic [8:0] pattern = 9'h000;
	pgacr_cfg_t ampConfig;
	int errors = 0;
	int samples_checked = 0;
	always #10 ref_clk = ~ref_clk;
	pgacr_regs i_dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .alarmEvent(alarmEvent), .irq(irq),
		.secondSelectCrcError(secondSelectCrcError), .ampConfig(ampConfig));
	pgacr_event_src i_src (.ref_clk(ref_clk), .fire(fire), .pattern(pattern),
		.alarmEvent(alarmEvent), .secondSelectCrcError(secondSelectCrcError));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (exp !== got) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		chk("answer", 32'h1, {31'h0, n < 50});
		rd = avs_readdata;
		rsp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		chk(what, {24'h0, exp}, rd);
		if (a[7:2] >= 6'h0E && a[7:2] <= 6'h14) begin
			chk("response", 32'h0, {30'h0, rsp});
		end
	endtask
	task automatic pulse(input logic [8:0] p);
		@(posedge ref_clk);
		fire <= 1'b1;
		pattern <= p;
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (12) @(posedge ref_clk);
	endtask
	task automatic t_reset();
		rdc("rsvA", 8'h38, RSV_RST);
		rdc("rsvB", 8'h3C, RSV_RST);
		rdc("mode", 8'h40, SWGAIN_RST);
		rdc("crc_error_revision", 8'h48, {4'h0, REV_DEFAULT});
		chk("cfg", 32'h50, {25'h0, ampConfig});
	endtask
	task automatic t_mode();
		logic [7:0] v;
		for (int i = 0; i < 24; i++) begin
			v = {1'b0, (i[0] ? SW_INT_CM : SW_EXTERNAL), i[4:1]};
			bus(1'b1, 8'h40, v);
			rdc("mode", 8'h40, v);
			chk("cfg", {24'h0, v}, {25'h0, ampConfig});
		end
		bus(1'b1, 8'h48, 8'h0F);
		rdc("revision", 8'h48, {4'h0, REV_DEFAULT});
	endtask
	task automatic t_alarm();
		bus(1'b1, 8'h50, 8'h01);
		pulse(9'h0A5);
		bus(1'b1, 8'h44, 8'h00);
		rdc("alarm", 8'h44, 8'hA5);
		rdc("alarm", 8'h44, 8'h00);
		chk("irq", 32'h1, {31'h0, irq});
		rdc("irqStat", 8'h4C, 8'h01);
		bus(1'b1, 8'h4C, 8'h01);
		chk("irq", 32'h0, {31'h0, irq});
	endtask
	task automatic t_crc();
		bus(1'b1, 8'h50, 8'h00);
		pulse(9'h100);
		chk("irq", 32'h0, {31'h0, irq});
		rdc("crc", 8'h48, {4'h1, REV_DEFAULT});
		rdc("crc", 8'h48, {4'h1, REV_DEFAULT});
		bus(1'b1, 8'h48, 8'h10);
		rdc("crc", 8'h48, {4'h1, REV_DEFAULT});
		bus(1'b1, 8'h48, 8'h00);
		rdc("crc", 8'h48, {4'h0, REV_DEFAULT});
	endtask
	task automatic t_unmapped();
		rdc("unmapped", 8'h00, 8'h00);
		chk("response", 32'h2, {30'h0, rsp});
	endtask
	task automatic conclude();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset();
		t_mode();
		t_alarm();
		t_crc();
		t_unmapped();
		conclude();
	end
endmodule // pgacr_regs_bench
